// ==== lgt_map.svh ====
// Register offsets, field positions and reset values of the lockup guard timer
`ifndef LGT_MAP_SVH
`define LGT_MAP_SVH

// Register byte offsets on the APB side
`define LGT_OFF_CTRL 8'h00
`define LGT_OFF_KICK 8'h04
`define LGT_OFF_CONFIG 8'h08
`define LGT_OFF_DELTA 8'h0C
`define LGT_OFF_PROTECT 8'h10
`define LGT_OFF_COUNT 8'h14
`define LGT_OFF_STATUS 8'h18
`define LGT_OFF_MASK 8'h1C

// Field positions
`define LGT_CTRL_EN_BIT 0
`define LGT_CTRL_DBG_BIT 1
`define LGT_CTRL_CLKSEL_BIT 2
`define LGT_KICK_BIT 0
`define LGT_PROT_BIT 0
`define LGT_CFG_RELOAD_LSB 0
`define LGT_CFG_PSC_LSB 12
`define LGT_EVT_UNDER 0
`define LGT_EVT_WINDOW 1

// Reset values
`define LGT_RST_CTRL 3'h0
`define LGT_RST_RELOAD 12'hFFF
`define LGT_RST_PSC 3'h0
`define LGT_RST_DELTA 12'hFFF
`define LGT_RST_MASK 2'h0

`endif

// ==== lgt_pkg.sv ====
// Types shared by the lockup guard timer files
`default_nettype none
package lgt_pkg;

  // Down-counter value
  typedef logic [11:0] lgt_cnt_t;

  // Control bits, packed in register bit order
  typedef struct packed {
    logic clk_ext;     // Count the external slow crystal
    logic dbg_freeze;  // Hold the count while the core is halted
    logic enable;      // Counting enabled
  } lgt_ctrl_s;

  // Configuration word, packed in register bit order
  typedef struct packed {
    logic [2:0] psc;   // Prescaler divides by two to this power
    lgt_cnt_t reload;  // Value loaded on each accepted reload
  } lgt_cfg_s;

endpackage : lgt_pkg

`default_nettype wire

// ==== lgt_prescaler.sv ====
// Power-of-two prescaler turning slow clock edges into count ticks
`timescale 1ns/100ps
`default_nettype none

module lgt_prescaler (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic slow_edge,
  input wire logic [2:0] div_sel,
  output logic tick
);

  logic [6:0] cnt_q;    // Slow edges seen since the last tick
  logic [7:0] one_hot;  // Single bit at the division position
  logic [6:0] mask;     // Low bits that must all be set for a tick
  logic done;           // Next slow edge completes a period

  assign one_hot = 8'h01 << div_sel;
  assign mask = one_hot[6:0] - 7'h01;
  assign done = ((cnt_q | ~mask) == 7'h7F);

  // Restart wins so that a reload always opens a full period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 7'h00;
      tick <= 1'b0;
    end else if (restart) begin
      cnt_q <= 7'h00;
      tick <= 1'b0;
    end else if (slow_edge) begin
      cnt_q <= done ? 7'h00 : cnt_q + 7'h01;
      tick <= done;
    end else begin
      tick <= 1'b0;
    end
  end

endmodule : lgt_prescaler

`default_nettype wire

// ==== lgt_lockup_guard_timer.sv ====
// Windowed lockup guard timer with APB registers and system reset request
`timescale 1ns/100ps
`default_nettype none
`include "lgt_map.svh"

module lgt_lockup_guard_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic internal_slow_oscillator,
  input wire logic external_slow_crystal,
  input wire logic debug_halted,
  output logic sys_reset_req,
  output logic irq
);

  // Address match, used by both the read mux and the write strobes
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction : reg_hit

  // Pin synchronisers: {halt, crystal, oscillator}
  logic [2:0] pin_s1_q;        // First stage, read only by second
  logic [2:0] pin_s2_q;        // Safe copies of the pins
  logic slow_dly_q;            // Previous level of the selected slow clock

  // Registers
  lgt_pkg::lgt_ctrl_s ctrl_q;
  lgt_pkg::lgt_cfg_s cfg_q;
  lgt_pkg::lgt_cnt_t delta_q;
  lgt_pkg::lgt_cnt_t cnt_q;
  lgt_pkg::lgt_cnt_t cnt_d;
  logic protect_q;             // Configuration locked
  logic [1:0] status_q;        // Sticky events
  logic [1:0] status_d;
  logic [1:0] mask_q;          // Interrupt enables per event

  // Bus decode
  logic setup;
  logic wr_en;
  logic known;
  logic [31:0] rd_mux;
  logic wr_ctrl;
  logic wr_cfg;
  logic wr_delta;
  logic wr_prot;
  logic wr_status;
  logic wr_mask;

  // Counting
  logic slow_lvl;
  logic slow_edge;
  logic dbg_halt;
  logic tick;
  logic run;
  logic kick;
  logic window_bad;
  logic kick_ok;
  logic under;
  logic [1:0] evt;

  // Two flops on every pin before any logic looks at it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      slow_dly_q <= 1'b0;
    end else begin
      pin_s1_q <= {debug_halted, external_slow_crystal,
                   internal_slow_oscillator};
      pin_s2_q <= pin_s1_q;
      slow_dly_q <= slow_lvl;
    end
  end

  // Count clock comes from a slow oscillator, never from pclk
  assign slow_lvl = ctrl_q.clk_ext ? pin_s2_q[1] : pin_s2_q[0];
  assign slow_edge = slow_lvl & ~slow_dly_q;
  assign dbg_halt = pin_s2_q[2];

  // APB decode; writes land on the access edge only
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;
  assign known = reg_hit(paddr, `LGT_OFF_CTRL) |
                 reg_hit(paddr, `LGT_OFF_KICK) |
                 reg_hit(paddr, `LGT_OFF_CONFIG) |
                 reg_hit(paddr, `LGT_OFF_DELTA) |
                 reg_hit(paddr, `LGT_OFF_PROTECT) |
                 reg_hit(paddr, `LGT_OFF_COUNT) |
                 reg_hit(paddr, `LGT_OFF_STATUS) |
                 reg_hit(paddr, `LGT_OFF_MASK);
  // Configuration strobes are gated by the protection bit
  assign wr_ctrl = wr_en & reg_hit(paddr, `LGT_OFF_CTRL) & ~protect_q;
  assign wr_cfg = wr_en & reg_hit(paddr, `LGT_OFF_CONFIG) & ~protect_q;
  assign wr_delta = wr_en & reg_hit(paddr, `LGT_OFF_DELTA) & ~protect_q;
  assign wr_prot = wr_en & reg_hit(paddr, `LGT_OFF_PROTECT);
  assign wr_status = wr_en & reg_hit(paddr, `LGT_OFF_STATUS);
  assign wr_mask = wr_en & reg_hit(paddr, `LGT_OFF_MASK);
  assign kick = wr_en & reg_hit(paddr, `LGT_OFF_KICK) &
                pwdata[`LGT_KICK_BIT];

  // Read data; kick register reads as zero
  assign rd_mux =
    reg_hit(paddr, `LGT_OFF_CTRL) ? {29'h0, ctrl_q} :
    reg_hit(paddr, `LGT_OFF_CONFIG) ? {17'h0, cfg_q} :
    reg_hit(paddr, `LGT_OFF_DELTA) ? {20'h0, delta_q} :
    reg_hit(paddr, `LGT_OFF_PROTECT) ? {31'h0, protect_q} :
    reg_hit(paddr, `LGT_OFF_COUNT) ? {20'h0, cnt_q} :
    reg_hit(paddr, `LGT_OFF_STATUS) ? {30'h0, status_q} :
    reg_hit(paddr, `LGT_OFF_MASK) ? {30'h0, mask_q} : 32'h0;

  // Bus answer: one registered wait-free access phase per transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~known;
      if (setup) begin
        prdata <= pwrite ? 32'h0 : rd_mux;
      end
    end
  end

  // Software-written registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `LGT_RST_CTRL;
      cfg_q <= {`LGT_RST_PSC, `LGT_RST_RELOAD};
      delta_q <= `LGT_RST_DELTA;
      protect_q <= 1'b0;
      mask_q <= `LGT_RST_MASK;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= pwdata[2:0];
      end
      if (wr_cfg) begin
        cfg_q <= pwdata[14:0];
      end
      if (wr_delta) begin
        delta_q <= pwdata[11:0];
      end
      // Protection stays writable so software can unlock it again
      if (wr_prot) begin
        protect_q <= pwdata[`LGT_PROT_BIT];
      end
      if (wr_mask) begin
        mask_q <= pwdata[1:0];
      end
    end
  end

  // Halt freezes the count only when software asked for it
  assign run = ctrl_q.enable & ~(ctrl_q.dbg_freeze & dbg_halt);
  // Reload too early in the period is a violation
  assign window_bad = kick & ctrl_q.enable & (cnt_q > delta_q);
  assign kick_ok = kick & ~window_bad;
  // A reload in the same cycle as the last tick saves the system
  assign under = run & tick & (cnt_q == 12'h000) & ~kick;
  assign evt = {window_bad, under};

  lgt_prescaler u_psc (
    .clk(pclk),
    .rst_n(presetn),
    .restart(kick_ok | ~ctrl_q.enable),
    .slow_edge(slow_edge),
    .div_sel(cfg_q.psc),
    .tick(tick)
  );

  // Next count: idle holds reload, accepted kick reloads, ticks count down
  always_comb begin
    cnt_d = cnt_q;
    if (!ctrl_q.enable || kick_ok) begin
      cnt_d = cfg_q.reload;
    end else if (run && tick && cnt_q != 12'h000) begin
      cnt_d = cnt_q - 12'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= `LGT_RST_RELOAD;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Sticky events: a new event wins over a write-one clear
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sticky
      assign status_d[gi] = evt[gi] |
        (status_q[gi] & ~(wr_status & pwdata[gi]));
    end
  endgenerate

  // Reset request holds until the system reset comes back to us
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= 2'h0;
      irq <= 1'b0;
      sys_reset_req <= 1'b0;
    end else begin
      status_q <= status_d;
      irq <= |(status_q & mask_q);
      sys_reset_req <= sys_reset_req | under | window_bad;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_underflow;
    under |=> sys_reset_req && status_q[`LGT_EVT_UNDER];
  endproperty
  a_underflow: assert property (p_underflow)
    else $error("underflow did not raise reset request");

  property p_hold_req;
    sys_reset_req |=> sys_reset_req;
  endproperty
  a_hold_req: assert property (p_hold_req)
    else $error("reset request dropped");

  property p_window;
    (kick && ctrl_q.enable && cnt_q > delta_q) |=>
      sys_reset_req && status_q[`LGT_EVT_WINDOW];
  endproperty
  a_window: assert property (p_window)
    else $error("early reload not flagged");

  property p_reload;
    (kick && ctrl_q.enable && cnt_q <= delta_q && !sys_reset_req) |=>
      cnt_q == $past(cfg_q.reload) && !sys_reset_req;
  endproperty
  a_reload: assert property (p_reload)
    else $error("accepted reload did not restore count");

  property p_decrement;
    (run && tick && !kick && cnt_q != 12'h000) |=>
      cnt_q == $past(cnt_q) - 12'h001;
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("count did not step down on tick");

  property p_freeze;
    (ctrl_q.enable && ctrl_q.dbg_freeze && dbg_halt && !kick) |=>
      cnt_q == $past(cnt_q);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("count moved while frozen");

  property p_protect;
    (protect_q && wr_en && reg_hit(paddr, `LGT_OFF_CONFIG)) |=>
      $stable(cfg_q);
  endproperty
  a_protect: assert property (p_protect)
    else $error("protected configuration changed");

  property p_tick_src;
    tick |-> $past(slow_edge);
  endproperty
  a_tick_src: assert property (p_tick_src)
    else $error("tick without slow clock edge");

  property p_irq;
    ##1 irq == |($past(status_q) & $past(mask_q));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt does not follow masked status");

  c_underflow: cover property (under ##1 sys_reset_req);
  c_window: cover property (window_bad);
  c_good_kick: cover property (kick_ok && ctrl_q.enable);
  c_freeze: cover property (ctrl_q.dbg_freeze && dbg_halt && tick);

endmodule : lgt_lockup_guard_timer

`default_nettype wire

// ==== test_lgt_lockup_guard_timer.sv ====
// Self-checking testbench of the lockup guard timer
`timescale 1ns/100ps
`default_nettype none
`include "lgt_map.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
  failures++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end

module test_lgt_lockup_guard_timer;
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv, c1;
  logic pready, pslverr, er, sys_reset_req, irq;
  logic debug_halted, run_int, run_ext;
  // Slow clock levels and their divider, driven only by the clock process
  logic slow_int = 1'b0;
  logic slow_ext = 1'b0;
  logic [1:0] div_q = 2'h0;
  int failures = 0;
  int checks = 0;
  int n;

  lgt_lockup_guard_timer lgt_lockup_guard_timer_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .internal_slow_oscillator(slow_int), .external_slow_crystal(slow_ext),
    .debug_halted(debug_halted), .sys_reset_req(sys_reset_req), .irq(irq)
  );

  // Bus clock, 8 ns period
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Slow oscillators, one period per 8 pclk; a stopped one stands still
  always @(posedge pclk) begin
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3) begin
      if (run_int) slow_int <= ~slow_int;
      if (run_ext) slow_ext <= ~slow_ext;
    end
  end

  task automatic conclude();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : do_reset

  // One APB transfer; waits for pready with a bound, never a fixed count
  task automatic apb(input logic wr, input logic [7:0] addr,
                     input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) failures++;
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Poll the count until it sits inside the window
  task automatic wait_window(input logic [11:0] lim);
    int k;
    k = 0;
    do begin
      apb(1'b0, `LGT_OFF_COUNT, 32'h0);
      k++;
    end while (rv[11:0] > lim && k < 100);
    // Never reaching the window is a failure of its own
    if (rv[11:0] > lim) failures++;
  endtask : wait_window

  task automatic t_reset_values();
    apb(1'b0, `LGT_OFF_CTRL, 32'h0);
    `CHK(rv, 32'h00000000)
    apb(1'b0, `LGT_OFF_CONFIG, 32'h0);
    `CHK(rv, 32'h00000FFF)
    apb(1'b0, `LGT_OFF_DELTA, 32'h0);
    `CHK(rv, 32'h00000FFF)
    apb(1'b0, `LGT_OFF_COUNT, 32'h0);
    `CHK(rv, 32'h00000FFF)
    // Unmapped place is refused
    apb(1'b1, 8'h20, 32'h00000001);
    `CHK(er, 1'b1)
  endtask : t_reset_values

  task automatic t_window_ok();
    apb(1'b1, `LGT_OFF_CONFIG, 32'h00000040);
    apb(1'b1, `LGT_OFF_DELTA, 32'h0000003C);
    apb(1'b1, `LGT_OFF_MASK, 32'h00000003);
    apb(1'b1, `LGT_OFF_CTRL, 32'h00000001);
    apb(1'b0, `LGT_OFF_COUNT, 32'h0);
    c1 = rv;
    repeat (32) @(posedge pclk);
    apb(1'b0, `LGT_OFF_COUNT, 32'h0);
    // Four ticks in 32 cycles, one either way for phase
    `CHK((c1 - rv) >= 32'h3 && (c1 - rv) <= 32'h5, 1'b1)
    wait_window(12'h03C);
    apb(1'b1, `LGT_OFF_KICK, 32'h00000001);
    apb(1'b0, `LGT_OFF_COUNT, 32'h0);
    `CHK(rv[11:0] > 12'h03C, 1'b1)
    `CHK(sys_reset_req, 1'b0)
  endtask : t_window_ok

  task automatic t_freeze();
    apb(1'b1, `LGT_OFF_CTRL, 32'h00000003);
    debug_halted <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b0, `LGT_OFF_COUNT, 32'h0);
    c1 = rv;
    repeat (40) @(posedge pclk);
    apb(1'b0, `LGT_OFF_COUNT, 32'h0);
    `CHK(rv, c1)
    debug_halted <= 1'b0;
    repeat (40) @(posedge pclk);
    apb(1'b0, `LGT_OFF_COUNT, 32'h0);
    `CHK(rv < c1, 1'b1)
  endtask : t_freeze

  task automatic t_protect();
    apb(1'b1, `LGT_OFF_PROTECT, 32'h00000001);
    apb(1'b1, `LGT_OFF_DELTA, 32'h00000005);
    apb(1'b1, `LGT_OFF_CONFIG, 32'h00007FFF);
    apb(1'b0, `LGT_OFF_DELTA, 32'h0);
    `CHK(rv, 32'h0000003C)
    apb(1'b0, `LGT_OFF_CONFIG, 32'h0);
    `CHK(rv, 32'h00000040)
    apb(1'b1, `LGT_OFF_PROTECT, 32'h00000000);
  endtask : t_protect

  task automatic t_violation();
    // An accepted reload, then a second one just above the delta
    wait_window(12'h03C);
    apb(1'b1, `LGT_OFF_KICK, 32'h00000001);
    `CHK(sys_reset_req, 1'b0)
    apb(1'b1, `LGT_OFF_KICK, 32'h00000001);
    repeat (3) @(posedge pclk);
    `CHK(sys_reset_req, 1'b1)
    apb(1'b0, `LGT_OFF_STATUS, 32'h0);
    `CHK(rv[1:0], 2'(1 << `LGT_EVT_WINDOW))
    `CHK(irq, 1'b1)
    apb(1'b1, `LGT_OFF_STATUS, 32'h00000002);
    repeat (3) @(posedge pclk);
    `CHK(irq, 1'b0)
    `CHK(sys_reset_req, 1'b1)
  endtask : t_violation

  task automatic t_underflow();
    // Counting from the crystal only, the internal source stopped
    do_reset();
    run_int <= 1'b0;
    run_ext <= 1'b1;
    // Reload of 8, prescaler set to divide the slow clock by two
    apb(1'b1, `LGT_OFF_CONFIG, 32'h00001008);
    apb(1'b1, `LGT_OFF_CTRL, 32'h00000005);
    n = 0;
    while (sys_reset_req !== 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    `CHK(sys_reset_req, 1'b1)
    `CHK(n > 60, 1'b1)
    // Nine ticks of sixteen cycles, plus the phase of the first one
    `CHK(n > 130 && n < 160, 1'b1)
    apb(1'b0, `LGT_OFF_STATUS, 32'h0);
    `CHK(rv[1:0], 2'(1 << `LGT_EVT_UNDER))
    `CHK(irq, 1'b0)
    apb(1'b1, `LGT_OFF_CTRL, 32'h00000000);
    apb(1'b1, `LGT_OFF_MASK, 32'h00000001);
    repeat (3) @(posedge pclk);
    `CHK(irq, 1'b1)
    apb(1'b1, `LGT_OFF_STATUS, 32'h00000001);
    repeat (3) @(posedge pclk);
    `CHK(irq, 1'b0)
  endtask : t_underflow

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    debug_halted = 1'b0;
    run_int = 1'b1;
    run_ext = 1'b0;
    do_reset();
    t_reset_values();
    t_window_ok();
    t_freeze();
    t_protect();
    t_violation();
    t_underflow();
    conclude();
  end

  // Hang guard, well past the few hundred cycles the run needs
  initial begin
    #200000;
    failures++;
    conclude();
  end
endmodule : test_lgt_lockup_guard_timer
`default_nettype wire
